/* File: core_offset_trim_registers.sv */
// How it works
// - Core 1 sampling input A uses bits 11:0 of its input-A trim register.
// - Core 1 sampling input B uses bits 11:0 of its input-B trim register.
// - Core 2 sampling input A uses bits 11:0 of its input-A trim register.
// - Core 2 sampling input B uses bits 11:0 of its input-B trim register.
// - Each trim field is an unsigned number, never sign-extended.
// - Trims reset to the factory value and software may read and rewrite it.
//
// The address-and-strobe port is this design's own decision.
module core_offset_trim_registers #(
    parameter logic [trim_pkg::TRIM_W-1:0] FACTORY_C1_INA = 12'h800,
    parameter logic [trim_pkg::TRIM_W-1:0] FACTORY_C1_INB = 12'h800,
    parameter logic [trim_pkg::TRIM_W-1:0] FACTORY_C2_INA = 12'h800,
    parameter logic [trim_pkg::TRIM_W-1:0] FACTORY_C2_INB = 12'h800
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // register port
    input wire logic [trim_pkg::ADDR_W-1:0] addr_i,
    input wire logic [trim_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [trim_pkg::DATA_W-1:0] rdata_o,
    // core input selection
    input wire logic [1:0] core1_input_sel_i,
    input wire logic [1:0] core2_input_sel_i,
    // applied offsets
    output logic [trim_pkg::TRIM_W-1:0] core1_offset_o,
    output logic [trim_pkg::TRIM_W-1:0] core2_offset_o,
    // all four trims, for the cores' own use
    output logic [trim_pkg::NUM_TRIM*trim_pkg::TRIM_W-1:0] trims_o
);

    // ------------------------------------------------------------
    // map and factory values
    // ------------------------------------------------------------
    localparam int NT = trim_pkg::NUM_TRIM;

    localparam int BW = trim_pkg::DATA_W;

    localparam int TW = trim_pkg::TRIM_W;

    localparam int NB = trim_pkg::BYTES_PER_REG;

    // register bases, one per trim
    localparam logic [trim_pkg::ADDR_W-1:0] BASE [NT] = '{
        trim_pkg::OFF_CORE1_INA,
        trim_pkg::OFF_CORE1_INB,
        trim_pkg::OFF_CORE2_INA,
        trim_pkg::OFF_CORE2_INB
    };

    // reset contents of the trim fields
    localparam logic [TW-1:0] FACT [NT] = '{
        FACTORY_C1_INA,
        FACTORY_C1_INB,
        FACTORY_C2_INA,
        FACTORY_C2_INB
    };

    // ------------------------------------------------------------
    // request
    // ------------------------------------------------------------
    trim_pkg::reg_req_t req;

    assign req = '{
        addr: addr_i,
        wdata: wdata_i,
        wr: wr_i,
        rd: rd_i
    };

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    trim_pkg::trim_reg_t regs_q [NT];

    trim_pkg::trim_reg_t regs_d [NT];

    // ------------------------------------------------------------
    // byte decode signals
    // ------------------------------------------------------------
    logic [NB-1:0] hit [NT];

    logic [NB-1:0] wr_byte [NT];

    logic [NT-1:0] hit_reg;

    logic hit_any;

    // ------------------------------------------------------------
    // byte lane signals
    // ------------------------------------------------------------
    logic [BW-1:0] cur_byte [NT][NB];

    logic [BW-1:0] new_byte [NT][NB];

    logic [BW-1:0] lane [NT][NB];

    logic [BW-1:0] reg_lane [NT];

    logic [BW-1:0] lane_or [NT+1];

    // ------------------------------------------------------------
    // read path signals
    // ------------------------------------------------------------
    logic rd_hit;

    logic [BW-1:0] rdata_d;

    logic [BW-1:0] rdata_q;

    // ------------------------------------------------------------
    // offset selection signals
    // ------------------------------------------------------------
    logic [TW-1:0] core1_trim_a;

    logic [TW-1:0] core1_trim_b;

    logic core1_use_b;

    logic [TW-1:0] core1_sel_trim;

    logic [TW-1:0] core2_trim_a;

    logic [TW-1:0] core2_trim_b;

    logic core2_use_b;

    logic [TW-1:0] core2_sel_trim;

    // ------------------------------------------------------------
    // byte decode
    // ------------------------------------------------------------
    genvar g;

    genvar b;

    generate
        for (g = 0; g < NT; g++) begin : g_decode
            for (b = 0; b < NB; b++) begin : g_byte
                // byte b of a register sits at its base plus b
                assign hit[g][b] =
                    (req.addr == BASE[g] + trim_pkg::ADDR_W'(b));

                // a byte is written only on its own address
                assign wr_byte[g][b] =
                    req.wr & hit[g][b];
            end

            assign hit_reg[g] =
                |hit[g];
        end
    endgenerate

    assign hit_any =
        |hit_reg;

    // ------------------------------------------------------------
    // register update
    // ------------------------------------------------------------
    // writes taken as given; software keeps off during calibration
    generate
        for (g = 0; g < NT; g++) begin : g_update
            localparam trim_pkg::trim_reg_t RESET_VAL = '{
                rsvd: trim_pkg::RSVD_RESET,
                trim: FACT[g]
            };

            for (b = 0; b < NB; b++) begin : g_byte
                assign cur_byte[g][b] =
                    regs_q[g][b*BW +: BW];

                // a write replaces the whole byte
                assign new_byte[g][b] =
                    wr_byte[g][b] ? req.wdata : cur_byte[g][b];
            end

            // reserved bits are plain storage beside the trim
            assign regs_d[g] = trim_pkg::trim_reg_t'({
                new_byte[g][trim_pkg::HI_BYTE],
                new_byte[g][trim_pkg::LO_BYTE]
            });

            // factory load at reset, rewritable after
            always_ff @(posedge clk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    regs_q[g] <= RESET_VAL;
                end else begin
                    regs_q[g] <= regs_d[g];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // read select
    // ------------------------------------------------------------
    // no read gating; software picks the moment
    generate
        for (g = 0; g < NT; g++) begin : g_read
            for (b = 0; b < NB; b++) begin : g_byte
                assign lane[g][b] =
                    hit[g][b] ? cur_byte[g][b] : trim_pkg::UNMAPPED_READ;
            end

            assign reg_lane[g] =
                lane[g][trim_pkg::HI_BYTE] | lane[g][trim_pkg::LO_BYTE];

            // or-chain keeps the read mux one gate per register
            assign lane_or[g+1] =
                lane_or[g] | reg_lane[g];
        end
    endgenerate

    assign lane_or[0] =
        trim_pkg::UNMAPPED_READ;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // unmapped bytes read zero, so a stray read cannot leak a trim
    assign rd_hit =
        req.rd & hit_any;

    assign rdata_d =
        rd_hit ? lane_or[NT] : trim_pkg::UNMAPPED_READ;

    // read data stands only the cycle after the strobe
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= trim_pkg::UNMAPPED_READ;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;

    // ------------------------------------------------------------
    // trim bus
    // ------------------------------------------------------------
    // each field leaves on its own slice
    generate
        for (g = 0; g < NT; g++) begin : g_bus
            assign trims_o[g*TW +: TW] =
                regs_q[g].trim;
        end
    endgenerate

    // ------------------------------------------------------------
    // core 1 select
    // ------------------------------------------------------------
    assign core1_trim_a =
        regs_q[trim_pkg::IDX_C1_INA].trim;

    assign core1_trim_b =
        regs_q[trim_pkg::IDX_C1_INB].trim;

    // codes other than input B fall back to input A
    assign core1_use_b =
        (core1_input_sel_i == trim_pkg::INPUT_B);

    // ------------------------------------------------------------
    // core 1 offset
    // ------------------------------------------------------------
    // pick by input; unsigned, never sign-extended
    assign core1_sel_trim =
        core1_use_b ? core1_trim_b : core1_trim_a;

    assign core1_offset_o =
        core1_sel_trim;

    // ------------------------------------------------------------
    // core 2 select
    // ------------------------------------------------------------
    assign core2_trim_a =
        regs_q[trim_pkg::IDX_C2_INA].trim;

    assign core2_trim_b =
        regs_q[trim_pkg::IDX_C2_INB].trim;

    // codes other than input B fall back to input A
    assign core2_use_b =
        (core2_input_sel_i == trim_pkg::INPUT_B);

    // ------------------------------------------------------------
    // core 2 offset
    // ------------------------------------------------------------
    // pick by input; unsigned, never sign-extended
    assign core2_sel_trim =
        core2_use_b ? core2_trim_b : core2_trim_a;

    assign core2_offset_o =
        core2_sel_trim;

endmodule : core_offset_trim_registers

/* File: core_offset_trim_registers_checker.sv */
module core_offset_trim_registers_checker (
    input wire logic clk_i, reset_n_i, wr_i, rd_i,
    input wire logic [11:0] addr_i, core1_offset_o, core2_offset_o,
    input wire logic [7:0] wdata_i, rdata_o,
    input wire logic [1:0] core1_input_sel_i, core2_input_sel_i,
    input wire logic [47:0] trims_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    chk_c1_input_a: assert property (core1_input_sel_i == 2'h1 |->
        core1_offset_o == trims_o[11:0]) else $error("core1 offset A");
    chk_c1_input_b: assert property (core1_input_sel_i == 2'h2 |->
        core1_offset_o == trims_o[23:12]) else $error("core1 offset B");
    chk_c2_input_a: assert property (core2_input_sel_i == 2'h1 |->
        core2_offset_o == trims_o[35:24]) else $error("core2 offset A");
    chk_c2_input_b: assert property (core2_input_sel_i == 2'h2 |->
        core2_offset_o == trims_o[47:36]) else $error("core2 offset B");
    chk_read_idle: assert property (!$past(rd_i) |->
        rdata_o == 8'h00) else $error("read data outside slot");
    chk_low_byte: assert property (wr_i && addr_i == 12'h08E |=>
        trims_o[7:0] == $past(wdata_i)) else $error("low byte lost");
    chk_high_nibble: assert property (wr_i && addr_i == 12'h08F |=>
        trims_o[11:8] == $past(wdata_i[3:0])) else $error("high byte lost");
    chk_trim_hold: assert property (!wr_i |=>
        $stable(trims_o)) else $error("trim changed without write");
endmodule : core_offset_trim_registers_checker

bind core_offset_trim_registers core_offset_trim_registers_checker chk_u (.*);

/* File: core_offset_trim_registers_test.sv */
module core_offset_trim_registers_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, reset_n_i = 0, wr_i = 0, rd_i = 0, pend = 0;
    logic [11:0] addr_i = 0, core1_offset_o, core2_offset_o;
    logic [7:0] wdata_i = 0, rdata_o;
    logic [1:0] core1_input_sel_i = 1, core2_input_sel_i = 2;
    logic [11:0] ex;
    logic [47:0] trims_o;
    logic [15:0] m [4];
    logic [7:0] q [$];
    int n_fail = 0, total_checks = 0, seed = 32'h5AB0, i;
    always #10 clk_i = ~clk_i;
    core_offset_trim_registers uut (.*);
    task automatic chk(input string n, input logic [47:0] e,
                       input logic [47:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk
    // mapped bytes only; others read zero
    function automatic logic [7:0] exp_byte(input logic [11:0] a);
        if (a < 12'h08E || a > 12'h095) return 8'h00;
        return m[(a - 12'h08E) >> 1][a[0] * 8 +: 8];
    endfunction : exp_byte
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a; wdata_i <= d; wr_i <= 1'b1;
        core1_input_sel_i <= 2'($random(seed));
        core2_input_sel_i <= 2'($random(seed));
        if (a >= 12'h08E && a <= 12'h095) m[(a - 12'h08E) >> 1][a[0]*8 +: 8] = d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [11:0] a);
        @(posedge clk_i);
        addr_i <= a; rd_i <= 1'b1;
        q.push_back(exp_byte(a));
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask : rd
    // result lands the cycle after the read strobe
    always @(posedge clk_i) begin
        if (pend) chk("rdata", 48'(q.pop_front()), 48'(rdata_o));
        pend <= rd_i;
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : print_verdict
    initial begin
        #50us;
        n_fail++;
        print_verdict();
    end
    initial begin
        // no calibration runs here, so every access is legal
        repeat (20) @(posedge clk_i);
        reset_n_i <= 1'b1;
        for (i = 0; i < 4; i++) m[i] = 16'h0800;
        for (i = 12'h08C; i < 12'h098; i++) rd(12'(i));
        for (i = 12'h08C; i < 12'h098; i++) wr(12'(i), 8'($random(seed)));
        for (i = 12'h08C; i < 12'h098; i++) rd(12'(i));
        // random mix keeps the order hazards live
        repeat (60) begin
            i = 12'h08C + {$random(seed)} % 12;
            if ($random(seed) & 1) wr(12'(i), 8'($random(seed)));
            else rd(12'(i));
        end
        repeat (3) @(posedge clk_i);
        chk("trims", {m[3][11:0], m[2][11:0], m[1][11:0], m[0][11:0]},
            trims_o);
        // every select code on both cores, read where settled
        for (i = 0; i < 4; i++) begin
            @(posedge clk_i);
            core1_input_sel_i <= 2'(i);
            core2_input_sel_i <= 2'(3 - i);
            @(negedge clk_i);
            ex = (i == 2) ? m[1][11:0] : m[0][11:0];
            chk("core1_offset", 48'(ex), 48'(core1_offset_o));
            ex = (i == 1) ? m[3][11:0] : m[2][11:0];
            chk("core2_offset", 48'(ex), 48'(core2_offset_o));
        end
        // a second reset in mid-run restores the factory values
        @(posedge clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        for (i = 0; i < 4; i++) m[i] = 16'h0800;
        rd(12'h08F);
        rd(12'h094);
        repeat (3) @(posedge clk_i);
        chk("trims", {4{12'h800}}, trims_o);
        print_verdict();
    end
endmodule : core_offset_trim_registers_test

/* File: trim_pkg.sv */
package trim_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int TRIM_W = 12;
    localparam int REG_W = 16;
    localparam int NUM_TRIM = 4;
    localparam int BYTES_PER_REG = REG_W / DATA_W;
    localparam int LO_BYTE = 0;
    localparam int HI_BYTE = 1;

    localparam logic [ADDR_W-1:0] OFF_CORE1_INA = 12'h08E;
    localparam logic [ADDR_W-1:0] OFF_CORE1_INB = 12'h090;
    localparam logic [ADDR_W-1:0] OFF_CORE2_INA = 12'h092;
    localparam logic [ADDR_W-1:0] OFF_CORE2_INB = 12'h094;

    localparam logic [3:0] RSVD_RESET = 4'h0;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

    // trim index order
    localparam int IDX_C1_INA = 0;
    localparam int IDX_C1_INB = 1;
    localparam int IDX_C2_INA = 2;
    localparam int IDX_C2_INB = 3;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic [3:0] rsvd;
        logic [TRIM_W-1:0] trim;
    } trim_reg_t;

    typedef enum logic [1:0] {
        INPUT_A = 2'b01,
        INPUT_B = 2'b10
    } input_sel_t;

endpackage : trim_pkg
